// ---- verilog/smf_consts.svh ----
`ifndef SMF_CONSTS_SVH
`define SMF_CONSTS_SVH

// Video geometry and markers
`define SMF_PIXELS      10'h200
`define SMF_PIX_MAX     16'h3fff
`define SMF_START_MARK  64'hffff00ffff000000
`define SMF_END_MARK    32'hfefe0000
`define SMF_MEM_WORDS   1536

// Measured value framing
`define SMF_MAX_VALUES  6'h20
`define SMF_NSRC        39
`define SMF_TAG_LOW     2'h0
`define SMF_TAG_MID     2'h1
`define SMF_TAG_FIRST   2'h2
`define SMF_TAG_HIGH    2'h3

// Error words
`define SMF_ERR_LIMIT   18'h3ffb8
`define SMF_ERR_UNDER   18'h3ffb9
`define SMF_ERR_OVER    18'h3ffba
`define SMF_ERR_BAUD    18'h3ffbb
`define SMF_ERR_NOPEAK  18'h3ffbc
`define SMF_ERR_BEFORE  18'h3ffbd
`define SMF_ERR_BEHIND  18'h3ffbe
`define SMF_ERR_NOCALC  18'h3ffbf

// Configuration refusal codes
`define SMF_CFG_BUSY    10'h106
`define SMF_CFG_TOOMANY 10'h154

// Timing
`define SMF_CLK_NS      50
`define SMF_STEP_NS     100
`define SMF_TS_NS       1000
`define SMF_STEP_CYC    (`SMF_STEP_NS / `SMF_CLK_NS)
`define SMF_TS_CYC      (`SMF_TS_NS / `SMF_CLK_NS)
`define SMF_TRIG_MAX    32'h000186a0

`endif

// ---- verilog/smf_pkg.sv ----
`default_nettype none
package smf_pkg;
    // Framer sequence
    typedef enum logic [2:0] {
        st_idle,
        st_start,
        st_size,
        st_pix,
        st_end,
        st_meas
    } state_t;

    typedef logic [17:0] word_t;
endpackage : smf_pkg
`default_nettype wire

// ---- verilog/value_tagger.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "smf_consts.svh"
module value_tagger (
    // Value in
    input  wire logic [17:0] word,
    input  wire logic        first,
    // Tagged bytes out
    output logic      [7:0]  byte_low,
    output logic      [7:0]  byte_mid,
    output logic      [7:0]  byte_high
);
    // Preamble tags on six data bits each
    assign byte_low  = {`SMF_TAG_LOW, word[5:0]};
    assign byte_mid  = {`SMF_TAG_MID, word[11:6]};
    assign byte_high = {first ? `SMF_TAG_FIRST : `SMF_TAG_HIGH, word[17:12]};
endmodule : value_tagger
`default_nettype wire

// ---- verilog/serial_measurement_framer.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "smf_consts.svh"
module serial_measurement_framer
    import smf_pkg::*;
(
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst,
    // Pixel capture
    input  wire logic         pix_wr_en,
    input  wire logic [1:0]   pix_wr_kind,
    input  wire logic [8:0]   pix_wr_index,
    input  wire logic [15:0]  pix_wr_data,
    // Measurement sources
    input  wire logic [31:0]  expo_cycles,
    input  wire logic [95:0]  enc_in,
    input  wire logic [83:0]  int_in,
    input  wire logic [107:0] dist_in,
    input  wire logic [269:0] thick_in,
    input  wire logic [17:0]  stat_min,
    input  wire logic [17:0]  stat_max,
    input  wire logic [17:0]  stat_pp,
    input  wire logic [31:0]  trig_cycles,
    input  wire logic [17:0]  symm_in,
    input  wire logic [15:0]  cap_bytes,
    input  wire logic         frame_trig,
    // Configuration
    input  wire logic         cfg_req,
    input  wire logic [38:0]  cfg_sel,
    input  wire logic [2:0]   cfg_video,
    output logic              cfg_ack,
    output logic              cfg_err,
    output logic      [9:0]   cfg_err_code,
    // Byte stream
    output logic      [7:0]   tx_data,
    output logic              tx_valid,
    input  wire logic         tx_ready,
    // Status
    output logic              busy,
    output logic              frame_done
);
    state_t       state;
    logic [15:0]  pix_mem [0:`SMF_MEM_WORDS-1];
    logic [38:0]  sel;
    logic [2:0]   vsel;
    logic [2:0]   frame_vsel;
    logic         frame_vid;
    word_t        vals [0:31];
    logic [5:0]   vcnt;
    logic [4:0]   vidx;
    logic [1:0]   part;
    logic [2:0]   fidx;
    logic [8:0]   pidx;
    logic [1:0]   kind;
    logic         half;
    logic [31:0]  mv_count;
    logic [35:0]  ts_us;
    logic [4:0]   ts_pre;
    word_t        src [0:38];
    logic [38:0]  src_isd;
    word_t        list [0:31];
    logic [31:0]  list_isd;
    logic [5:0]   sel_cnt;
    logic [5:0]   cfg_cnt;
    logic         over_cap;
    logic [31:0]  trig_word;
    logic [63:0]  start_mark;
    logic [31:0]  end_mark;
    logic [31:0]  size_word;
    logic [1:0]   nsel;
    logic [7:0]   next_byte;
    logic         load;
    logic         last;
    logic         trig_take;
    logic [7:0]   tb_low;
    logic [7:0]   tb_mid;
    logic [7:0]   tb_high;
    logic [2:0]   next_k;

    assign start_mark = `SMF_START_MARK;
    assign end_mark   = `SMF_END_MARK;
    assign nsel       = 2'(frame_vsel[0] + frame_vsel[1] + frame_vsel[2]);
    assign size_word  = {20'h00000, nsel, 10'h000};
    assign load       = (state != st_idle) && (!tx_valid || tx_ready);
    assign trig_take  = frame_trig && (state == st_idle);

    // Next selected video kind after the current one: {found, kind}
    function automatic logic [2:0] kind_after(input logic [2:0] v, input logic [1:0] k);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 2; i >= 0; i--) begin
            if (v[i] && (2'(i) > k)) begin
                r = {1'b1, 2'(i)};
            end
        end
        return r;
    endfunction : kind_after

    // Lowest selected video kind
    function automatic logic [1:0] kind_first(input logic [2:0] v);
        logic [1:0] r;
        r = 2'h0;
        for (int i = 2; i >= 0; i--) begin
            if (v[i]) begin
                r = 2'(i);
            end
        end
        return r;
    endfunction : kind_first

    // Trigger difference in 100 ns steps, saturated
    always_comb begin
        trig_word = trig_cycles / `SMF_STEP_CYC;
        if (trig_word > `SMF_TRIG_MAX) begin
            trig_word = `SMF_TRIG_MAX;
        end
    end

    // Source words in transmission order
    always_comb begin
        src_isd = 39'h0;
        src[0] = 18'((expo_cycles / `SMF_STEP_CYC) & 32'h0003ffff);
        for (int e = 0; e < 3; e++) begin
            src[1 + e] = enc_in[32*e +: 18];
        end
        for (int d = 0; d < 6; d++) begin
            src[4 + 2*d] = {8'h00, int_in[14*d + 4 +: 10]};
            src[5 + 2*d] = dist_in[18*d +: 18];
            src_isd[5 + 2*d] = 1'b1;
        end
        for (int t = 0; t < 15; t++) begin
            src[16 + t] = thick_in[18*t +: 18];
            src_isd[16 + t] = 1'b1;
        end
        src[31] = stat_min;
        src[32] = stat_max;
        src[33] = stat_pp;
        src_isd[33:31] = 3'h7;
        src[34] = trig_word[17:0];
        src[35] = mv_count[17:0];
        src[36] = ts_us[17:0];
        src[37] = ts_us[35:18];
        src[38] = symm_in;
    end

    // Compact the selected sources into a dense list
    always_comb begin
        logic [5:0] n;
        n = 6'h00;
        for (int j = 0; j < 32; j++) begin
            list[j] = 18'h00000;
        end
        list_isd = 32'h0;
        for (int i = 0; i < `SMF_NSRC; i++) begin
            if (sel[i] && (n < `SMF_MAX_VALUES)) begin
                list[n[4:0]] = src[i];
                list_isd[n[4:0]] = src_isd[i];
                n = 6'(n + 6'h01);
            end
        end
        sel_cnt = n;
    end

    // Number of values in a configuration request
    always_comb begin
        cfg_cnt = 6'h00;
        for (int i = 0; i < `SMF_NSRC; i++) begin
            cfg_cnt = 6'(cfg_cnt + {5'h00, cfg_sel[i]});
        end
    end

    assign over_cap = ({8'h00, sel_cnt, 2'b00} - {10'h000, sel_cnt}) > cap_bytes;

    // Pixel capture memory, clamped to the converter range
    always_ff @(posedge clk_sys) begin
        if (pix_wr_en && (pix_wr_kind != 2'h3)) begin
            pix_mem[{pix_wr_kind, pix_wr_index}] <=
                (pix_wr_data > `SMF_PIX_MAX) ? `SMF_PIX_MAX : pix_wr_data;
        end
    end

    // Configuration accept or refuse
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sel          <= 39'h0;
            vsel         <= 3'h0;
            cfg_ack      <= 1'b0;
            cfg_err      <= 1'b0;
            cfg_err_code <= 10'h000;
        end else begin
            cfg_ack <= 1'b0;
            cfg_err <= 1'b0;
            if (cfg_req) begin
                if (state != st_idle) begin
                    cfg_err      <= 1'b1;
                    cfg_err_code <= `SMF_CFG_BUSY;
                end else if (cfg_cnt > `SMF_MAX_VALUES) begin
                    cfg_err      <= 1'b1;
                    cfg_err_code <= `SMF_CFG_TOOMANY;
                end else begin
                    cfg_ack      <= 1'b1;
                    cfg_err_code <= 10'h000;
                    sel          <= cfg_sel;
                    vsel         <= cfg_video;
                end
            end
        end
    end

    // Microsecond timestamp
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ts_pre <= 5'h00;
            ts_us  <= 36'h0;
        end else if (ts_pre == 5'(`SMF_TS_CYC - 1)) begin
            ts_pre <= 5'h00;
            ts_us  <= 36'(ts_us + 36'h1);
        end else begin
            ts_pre <= 5'(ts_pre + 5'h01);
        end
    end

    // Snapshot of the value list at frame start
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            vcnt       <= 6'h00;
            frame_vsel <= 3'h0;
            frame_vid  <= 1'b0;
            for (int j = 0; j < 32; j++) begin
                vals[j] <= 18'h00000;
            end
        end else if (trig_take) begin
            vcnt       <= sel_cnt;
            frame_vsel <= vsel;
            frame_vid  <= |vsel;
            for (int j = 0; j < 32; j++) begin
                vals[j] <= (over_cap && list_isd[j]) ? `SMF_ERR_BAUD : list[j];
            end
        end
    end

    value_tagger u_tagger (
        .word      (vals[vidx]),
        .first     (vidx == 5'h00),
        .byte_low  (tb_low),
        .byte_mid  (tb_mid),
        .byte_high (tb_high)
    );

    assign next_k = kind_after(frame_vsel, kind);

    // Byte for the current position
    always_comb begin
        next_byte = 8'h00;
        last      = 1'b0;
        unique case (state)
            st_idle: begin
                next_byte = 8'h00;
            end
            st_start: begin
                next_byte = start_mark[{3'(3'h7 - fidx), 3'b000} +: 8];
            end
            st_size: begin
                next_byte = size_word[{2'(2'h3 - fidx[1:0]), 3'b000} +: 8];
            end
            st_pix: begin
                next_byte = half ? pix_mem[{kind, pidx}][7:0] : pix_mem[{kind, pidx}][15:8];
            end
            st_end: begin
                next_byte = end_mark[{2'(2'h3 - fidx[1:0]), 3'b000} +: 8];
                last      = (fidx == 3'h3) && (vcnt == 6'h00);
            end
            st_meas: begin
                next_byte = (part == 2'h0) ? tb_low : (part == 2'h1) ? tb_mid : tb_high;
                last      = (part == 2'h2) && ({1'b0, vidx} == 6'(vcnt - 6'h01));
            end
        endcase
    end

    // Frame sequencing and byte output
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state      <= st_idle;
            tx_data    <= 8'h00;
            tx_valid   <= 1'b0;
            fidx       <= 3'h0;
            pidx       <= 9'h000;
            kind       <= 2'h0;
            half       <= 1'b0;
            vidx       <= 5'h00;
            part       <= 2'h0;
            busy       <= 1'b0;
            frame_done <= 1'b0;
            mv_count   <= 32'h0;
        end else begin
            frame_done <= 1'b0;
            if (trig_take && ((|vsel) || (sel_cnt != 6'h00))) begin
                state <= (|vsel) ? st_start : st_meas;
                fidx  <= 3'h0;
                vidx  <= 5'h00;
                part  <= 2'h0;
                busy  <= 1'b1;
            end else if (load) begin
                tx_data  <= next_byte;
                tx_valid <= 1'b1;
                fidx     <= 3'(fidx + 3'h1);
                unique case (state)
                    st_idle: begin
                        state <= st_idle;
                    end
                    st_start: begin
                        if (fidx == 3'h7) begin
                            state <= st_size;
                        end
                    end
                    st_size: begin
                        if (fidx == 3'h3) begin
                            state <= st_pix;
                            pidx  <= 9'h000;
                            kind  <= kind_first(frame_vsel);
                            half  <= 1'b0;
                        end
                    end
                    st_pix: begin
                        fidx <= 3'h0;
                        half <= ~half;
                        if (half) begin
                            if (next_k[2]) begin
                                kind <= next_k[1:0];
                            end else begin
                                kind <= kind_first(frame_vsel);
                                pidx <= 9'(pidx + 9'h001);
                                if ({1'b0, pidx} == 10'(`SMF_PIXELS - 10'h001)) begin
                                    state <= st_end;
                                end
                            end
                        end
                    end
                    st_end: begin
                        if (fidx == 3'h3) begin
                            state <= st_meas;
                        end
                    end
                    st_meas: begin
                        part <= (part == 2'h2) ? 2'h0 : 2'(part + 2'h1);
                        if (part == 2'h2) begin
                            vidx <= 5'(vidx + 5'h01);
                        end
                    end
                endcase
                if (last) begin
                    state      <= st_idle;
                    busy       <= 1'b0;
                    frame_done <= 1'b1;
                    mv_count   <= 32'(mv_count + 32'h1);
                end
            end else if (tx_valid && tx_ready) begin
                tx_valid <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence ld_start_s;
        load && (state == st_start) && (fidx == 3'h0);
    endsequence
    sequence ld_end_s;
        load && (state == st_end) && (fidx == 3'h0);
    endsequence
    sequence ld_high_s;
        load && (state == st_meas) && (part == 2'h2);
    endsequence

    start_marker_a: assert property (ld_start_s |=> tx_valid && (tx_data == 8'hff))
        else $error("start marker byte wrong");
    end_marker_a: assert property (ld_end_s |=> tx_valid && (tx_data == 8'hfe))
        else $error("end marker byte wrong");
    low_tag_a: assert property (load && (state == st_meas) && (part == 2'h0) |=> tx_data[7:6] == 2'h0)
        else $error("low byte tag wrong");
    high_tag_a: assert property (ld_high_s |=> tx_data[7:6] == (($past(vidx) == 5'h00) ? 2'h2 : 2'h3))
        else $error("high byte tag wrong");
    meas_order_a: assert property ($changed(state) && (state == st_meas) && frame_vid |-> $past(state) == st_end)
        else $error("values sent before video");
    cfg_busy_a: assert property (cfg_req && (state != st_idle) |=> cfg_err && (cfg_err_code == 10'h106) && !cfg_ack)
        else $error("busy configuration not refused");
    cfg_many_a: assert property (cfg_req && (state == st_idle) && (cfg_cnt > 6'h20) |=> cfg_err && (cfg_err_code == 10'h154))
        else $error("oversized selection not refused");
    tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("byte changed while stalled");
    baud_sub_a: assert property (trig_take && over_cap && list_isd[0] |=> vals[0] == 18'h3ffbb)
        else $error("too-much-data code missing");
    trig_clamp_a: assert property (trig_word <= 32'h000186a0)
        else $error("trigger difference above limit");
    value_bytes_a: assert property (load && (state == st_meas) && (part == 2'h0) |=> (part == 2'h1) && (state == st_meas))
        else $error("value bytes split");
endmodule : serial_measurement_framer
`default_nettype wire

// ---- verification/host_receiver_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_receiver_model (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Byte stream
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    // Control
    input  wire logic       stall_en
);
    integer seed = 29919;

    // Accepts bytes, stalling at random when asked
    always @(posedge clk_sys) begin
        if (rst) begin
            tx_ready <= 1'b0;
        end else begin
            tx_ready <= stall_en ? $random(seed) : 1'b1;
        end
    end
endmodule : host_receiver_model
`default_nettype wire

// ---- verification/serial_measurement_framer_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module serial_measurement_framer_tb;
    import smf_pkg::*;
    logic         clk_sys = 1'b0;
    logic         rst = 1'b1;
    logic         pix_wr_en = 1'b0;
    logic [1:0]   pix_wr_kind = 2'h0;
    logic [8:0]   pix_wr_index = 9'h0;
    logic [15:0]  pix_wr_data = 16'h0;
    logic [31:0]  expo_cycles = 32'h0;
    logic [95:0]  enc_in = 96'h0;
    logic [83:0]  int_in = 84'h0;
    logic [107:0] dist_in = 108'h0;
    logic [269:0] thick_in = 270'h0;
    logic [17:0]  stat_min = 18'h0;
    logic [17:0]  stat_max = 18'h0;
    logic [17:0]  stat_pp = 18'h0;
    logic [31:0]  trig_cycles = 32'h0;
    logic [17:0]  symm_in = 18'h0;
    logic [15:0]  cap_bytes = 16'hffff;
    logic         frame_trig = 1'b0;
    logic         cfg_req = 1'b0;
    logic [38:0]  cfg_sel = 39'h0;
    logic [2:0]   cfg_video = 3'h0;
    logic         cfg_ack;
    logic         cfg_err;
    logic [9:0]   cfg_err_code;
    logic [7:0]   tx_data;
    logic         tx_valid;
    logic         tx_ready;
    logic         busy;
    logic         frame_done;
    logic         stall_en = 1'b0;
    logic [7:0]   exp_q[$];
    logic [7:0]   exp_b;
    integer       seed = 29919;
    integer       err_total = 0;
    integer       checks = 0;
    integer       done_seen = 0;
    integer       range_span_mm = 10;
    integer       i;

    serial_measurement_framer i_dut (
        .clk_sys(clk_sys), .rst(rst), .pix_wr_en(pix_wr_en), .pix_wr_kind(pix_wr_kind),
        .pix_wr_index(pix_wr_index), .pix_wr_data(pix_wr_data), .expo_cycles(expo_cycles),
        .enc_in(enc_in), .int_in(int_in), .dist_in(dist_in), .thick_in(thick_in),
        .stat_min(stat_min), .stat_max(stat_max), .stat_pp(stat_pp),
        .trig_cycles(trig_cycles), .symm_in(symm_in), .cap_bytes(cap_bytes),
        .frame_trig(frame_trig), .cfg_req(cfg_req), .cfg_sel(cfg_sel), .cfg_video(cfg_video),
        .cfg_ack(cfg_ack), .cfg_err(cfg_err), .cfg_err_code(cfg_err_code),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .busy(busy), .frame_done(frame_done)
    );

    host_receiver_model i_host (
        .clk_sys(clk_sys), .rst(rst), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .stall_en(stall_en)
    );

    // 20 MHz clock
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish;
        if (err_total == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish

    // Notes one tagged value as three bytes
    task automatic note_word(input logic [17:0] w, input logic first);
        exp_q.push_back({2'h0, w[5:0]});
        exp_q.push_back({2'h1, w[11:6]});
        exp_q.push_back({first ? 2'h2 : 2'h3, w[17:12]});
    endtask : note_word

    task automatic note_bytes(input logic [63:0] v, input integer n);
        for (int k = n - 1; k >= 0; k--) begin
            exp_q.push_back(v[8*k+:8]);
        end
    endtask : note_bytes

    task automatic configure(input logic [38:0] sel, input logic [2:0] vid,
                             input logic ack, input logic [9:0] code);
        @(posedge clk_sys);
        cfg_req <= 1'b1;
        cfg_sel <= sel;
        cfg_video <= vid;
        @(posedge clk_sys);
        cfg_req <= 1'b0;
        #1;
        check("cfg_ack", cfg_ack, ack);
        check("cfg_err", cfg_err, !ack);
        check("cfg_err_code", cfg_err_code, code);
    endtask : configure

    task automatic trigger_and_drain;
        integer d0;
        d0 = done_seen;
        @(posedge clk_sys);
        frame_trig <= 1'b1;
        @(posedge clk_sys);
        frame_trig <= 1'b0;
        for (i = 0; i < 5000 && exp_q.size() != 0; i++) begin
            @(posedge clk_sys);
        end
        check("bytes left", exp_q.size(), 0);
        repeat (4) @(posedge clk_sys);
        #1;
        check("busy idle", busy, 1'b0);
        check("tx_valid idle", tx_valid, 1'b0);
        check("frame_done", done_seen - d0, 1);
    endtask : trigger_and_drain

    // Compares each accepted byte with the oldest note
    always @(posedge clk_sys) begin
        if (!rst && frame_done === 1'b1) begin
            done_seen = done_seen + 1;
        end
        if (!rst && tx_valid === 1'b1 && tx_ready === 1'b1) begin
            exp_b = exp_q.size() != 0 ? exp_q.pop_front() : 8'hxx;
            check("tx_data", tx_data, exp_b);
        end
    end

    // Cuts a hang short
    initial begin
        #(50 * 40000);
        err_total = err_total + 1;
        tally_and_finish();
    end

    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        check("tx_valid reset", tx_valid, 1'b0);
        check("busy reset", busy, 1'b0);
        // Receiver scaling: mid-range word maps to half the span
        check("mid range mm", ((131000 - 98232) * range_span_mm) / 65536, range_span_mm / 2);
        // Raw and dark corrected pixels with clamping
        note_bytes(64'hffff00ffff000000, 8);
        note_bytes(64'h00000800, 4);
        for (int p = 0; p < 512; p++) begin
            for (int k = 0; k < 2; k++) begin
                @(posedge clk_sys);
                pix_wr_en <= 1'b1;
                pix_wr_kind <= k[1:0];
                pix_wr_index <= p[8:0];
                pix_wr_data <= $random(seed);
                #1;
                note_bytes(pix_wr_data > 16'h3fff ? 64'h3fff : {48'h0, pix_wr_data}, 2);
            end
        end
        @(posedge clk_sys);
        pix_wr_en <= 1'b0;
        note_bytes(64'hfefe0000, 4);
        expo_cycles <= $random(seed);
        enc_in <= {$random(seed), $random(seed), $random(seed)};
        int_in <= {$random(seed), $random(seed), $random(seed)};
        dist_in <= {$random(seed), $random(seed), $random(seed), $random(seed)};
        thick_in <= {9{$random(seed)}};
        stat_min <= $random(seed);
        stat_max <= $random(seed);
        stat_pp <= $random(seed);
        trig_cycles <= 32'h00100000;
        symm_in <= 18'h3fff0;
        stall_en <= 1'b1;
        configure({39{1'b1}}, 3'h1, 1'b0, 10'h154);
        configure(39'h4780010033, 3'h3, 1'b1, 10'h0);
        #1;
        note_word(expo_cycles[18:1], 1'b1);
        note_word(enc_in[17:0], 1'b0);
        note_word({8'h0, int_in[13:4]}, 1'b0);
        note_word(dist_in[17:0], 1'b0);
        note_word(thick_in[17:0], 1'b0);
        note_word(stat_min, 1'b0);
        note_word(stat_max, 1'b0);
        note_word(stat_pp, 1'b0);
        note_word(18'h186a0, 1'b0);
        note_word(18'h3fff0, 1'b0);
        fork
            trigger_and_drain();
            begin
                repeat (6) @(posedge clk_sys);
                frame_trig <= 1'b1;
                configure(39'h1, 3'h0, 1'b0, 10'h106);
                frame_trig <= 1'b0;
            end
        join
        // Values only, over capacity
        cap_bytes <= 16'h000b;
        configure(39'h880010020, 3'h0, 1'b1, 10'h0);
        note_word(18'h3ffbb, 1'b1);
        note_word(18'h3ffbb, 1'b0);
        note_word(18'h3ffbb, 1'b0);
        note_word(18'h00001, 1'b0);
        trigger_and_drain();
        tally_and_finish();
    end
endmodule : serial_measurement_framer_tb
`default_nettype wire
